// file: logic/sdl_map.svh
`ifndef SDL_MAP_SVH
`define SDL_MAP_SVH

// ************************************************************
// Word layout
// ************************************************************
`define SDL_WORD_W 16
`define SDL_MSB 15

// ************************************************************
// Code points
// ************************************************************
`define SDL_BIPOLAR_ZERO 16'h0000
`define SDL_PLUS_FULL 16'h7FFF
`define SDL_MINUS_FULL 16'h8000
`define SDL_OFFSET_FLIP 16'h8000

// ************************************************************
// Buffering
// ************************************************************
`define SDL_FIFO_DEPTH 32

`endif

// file: logic/sdl_pkg.sv
`default_nettype none

package sdl_pkg;

   // ************************************************************
   // Types
   // ************************************************************
   typedef logic [15:0] sdl_word_t;

   typedef enum logic [3:0]
   {
      SDL_MODE_HOLD     = 4'b0001,
      SDL_MODE_SHIFT    = 4'b0010,
      SDL_MODE_LOAD     = 4'b0100,
      SDL_MODE_TWO_WIRE = 4'b1000
   } sdl_mode_t;

   typedef enum logic [1:0]
   {
      SDL_CAP_IDLE = 2'b01,
      SDL_CAP_WAIT = 2'b10
   } sdl_cap_state_t;

endpackage

`default_nettype wire

// file: logic/sdl_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module sdl_fifo
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
)
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_wr_valid,
   output logic o_wr_ready,
   input wire logic [WIDTH-1:0] i_wr_data,
   output logic o_rd_valid,
   input wire logic i_rd_ready,
   output logic [WIDTH-1:0] o_rd_data
);
   import sdl_pkg::*;

   localparam int AW = $clog2(DEPTH);

   // ************************************************************
   // Storage and pointers
   // ************************************************************
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr_reg;
   logic [AW-1:0] rptr_reg;
   logic [AW:0] cnt_reg;
   logic [WIDTH-1:0] rdata_reg;
   logic rvalid_reg;

   wire push = i_wr_valid && o_wr_ready;
   wire fetch = (cnt_reg != '0) && (!rvalid_reg || i_rd_ready);
   wire drain = rvalid_reg && i_rd_ready;

   assign o_wr_ready = (cnt_reg != (AW+1)'(DEPTH));
   assign o_rd_valid = rvalid_reg;
   assign o_rd_data = rdata_reg;

   always_ff @(posedge i_clk)
   begin
      if (push)
      begin
         mem[wptr_reg] <= i_wr_data;
      end
      if (fetch)
      begin
         rdata_reg <= mem[rptr_reg];
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         cnt_reg <= '0;
         rvalid_reg <= 1'b0;
      end
      else
      begin
         wptr_reg <= wptr_reg + AW'(push);
         rptr_reg <= rptr_reg + AW'(fetch);
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(fetch);
         rvalid_reg <= fetch ? 1'b1 : (drain ? 1'b0 : rvalid_reg);
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   property p_fifo_hold;
      @(posedge i_clk) disable iff (i_reset)
      (rvalid_reg && !i_rd_ready) |=> (rvalid_reg && $stable(rdata_reg));
   endproperty
   a_fifo_hold: assert property (p_fifo_hold) else $error("fifo output changed while stalled");

endmodule

`default_nettype wire

// file: logic/sdl_serial_dac_latches.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdl_map.svh"

// ************************************************************
// Overview of operation
// - Enable input low, converter enable high, clear high: each pulse shifts serial_in in.
// - Two buffers; pulse with only converter enable low copies input latch to converter.
// - With both enables high or clock idle high, neither latch changes.
// - Latches are edge-triggered on the sclk rise; data enters every pulse while enable stays low.
// - Both enables low: both latches transparent, converter follows shifted word.
// - Clear low resets both latches to bipolar zero, regardless of enables and clock.
// - Latch enables and clear are active low; i_reset is active high.
// - 7FFF is plus full scale, 8000 minus full scale, 0000 bipolar zero.
// - Input latch top bit drives serial_out for daisy chaining.
// ************************************************************
module sdl_serial_dac_latches
#(
   parameter int FIFO_DEPTH = `SDL_FIFO_DEPTH
)
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_sclk,
   input wire logic i_input_latch_enable_n,
   input wire logic i_dac_latch_enable_n,
   input wire logic i_latch_reset_n,
   input wire logic i_serial_in,
   output logic o_serial_out,
   output sdl_pkg::sdl_word_t o_dac_code,
   output sdl_pkg::sdl_word_t o_offset_code,
   output logic o_plus_full,
   output logic o_minus_full,
   output logic o_bipolar_zero,
   output sdl_pkg::sdl_word_t o_code_data,
   output logic o_code_valid,
   input wire logic i_code_ready,
   output logic o_clear_active,
   output logic o_overrun
);
   import sdl_pkg::*;

   // ************************************************************
   // Link side declarations
   // ************************************************************
   sdl_word_t shift_reg;
   sdl_word_t shift_next;
   sdl_word_t conv_reg;
   sdl_word_t conv_next;
   sdl_word_t offset_reg;
   logic plus_reg;
   logic minus_reg;
   logic zero_reg;
   logic load_tgl_reg;
   sdl_mode_t link_mode;

   // ************************************************************
   // System side declarations
   // ************************************************************
   logic tgl_meta_reg;
   logic tgl_sync_reg;
   logic tgl_seen_reg;
   logic clr_meta_reg;
   logic clr_sync_reg;
   sdl_word_t word_reg;
   sdl_cap_state_t cap_reg;
   sdl_cap_state_t cap_next;
   logic overrun_reg;
   logic fifo_wr_ready;

   // ************************************************************
   // Mode decode
   // ************************************************************
   wire in_en = !i_input_latch_enable_n;
   wire dac_en = !i_dac_latch_enable_n;

   assign link_mode = (in_en && dac_en) ? SDL_MODE_TWO_WIRE :
                      (in_en) ? SDL_MODE_SHIFT :
                      (dac_en) ? SDL_MODE_LOAD :
                      SDL_MODE_HOLD;

   wire do_shift = (link_mode == SDL_MODE_SHIFT) || (link_mode == SDL_MODE_TWO_WIRE);
   wire do_load = (link_mode == SDL_MODE_LOAD) || (link_mode == SDL_MODE_TWO_WIRE);

   // ************************************************************
   // Next values of the two latches
   // ************************************************************
   assign shift_next = do_shift ? {shift_reg[`SDL_MSB-1:0], i_serial_in} : shift_reg;

   assign conv_next = (link_mode == SDL_MODE_TWO_WIRE) ? shift_next :
                      (link_mode == SDL_MODE_LOAD) ? shift_reg :
                      conv_reg;

   // ************************************************************
   // Input latch, clocked at the end of each pulse
   // ************************************************************
   always_ff @(posedge i_sclk or negedge i_latch_reset_n)
   begin
      if (!i_latch_reset_n)
      begin
         shift_reg <= `SDL_BIPOLAR_ZERO;
      end
      else
      begin
         shift_reg <= shift_next;
      end
   end

   // ************************************************************
   // Converter latch and decoded code
   // ************************************************************
   always_ff @(posedge i_sclk or negedge i_latch_reset_n)
   begin
      if (!i_latch_reset_n)
      begin
         conv_reg <= `SDL_BIPOLAR_ZERO;
         offset_reg <= `SDL_BIPOLAR_ZERO ^ `SDL_OFFSET_FLIP;
         plus_reg <= 1'b0;
         minus_reg <= 1'b0;
         zero_reg <= 1'b1;
      end
      else
      begin
         conv_reg <= conv_next;
         offset_reg <= conv_next ^ `SDL_OFFSET_FLIP;
         plus_reg <= (conv_next == `SDL_PLUS_FULL);
         minus_reg <= (conv_next == `SDL_MINUS_FULL);
         zero_reg <= (conv_next == `SDL_BIPOLAR_ZERO);
      end
   end

   // ************************************************************
   // Load event toggle toward the system clock
   // ************************************************************
   always_ff @(posedge i_sclk or negedge i_latch_reset_n)
   begin
      if (!i_latch_reset_n)
      begin
         load_tgl_reg <= 1'b0;
      end
      else
      begin
         load_tgl_reg <= load_tgl_reg ^ do_load;
      end
   end

   assign o_serial_out = shift_reg[`SDL_MSB];
   assign o_dac_code = conv_reg;
   assign o_offset_code = offset_reg;
   assign o_plus_full = plus_reg;
   assign o_minus_full = minus_reg;
   assign o_bipolar_zero = zero_reg;

   // ************************************************************
   // Crossing into the system clock
   // ************************************************************
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         tgl_meta_reg <= 1'b0;
         tgl_sync_reg <= 1'b0;
         tgl_seen_reg <= 1'b0;
         clr_meta_reg <= 1'b0;
         clr_sync_reg <= 1'b0;
      end
      else
      begin
         tgl_meta_reg <= load_tgl_reg;
         tgl_sync_reg <= tgl_meta_reg;
         tgl_seen_reg <= tgl_sync_reg;
         clr_meta_reg <= i_latch_reset_n;
         clr_sync_reg <= clr_meta_reg;
      end
   end

   wire load_event = tgl_sync_reg ^ tgl_seen_reg;
   wire push = (cap_reg == SDL_CAP_WAIT) && fifo_wr_ready;

   assign o_clear_active = !clr_sync_reg;
   assign o_overrun = overrun_reg;

   // ************************************************************
   // Capture state machine
   // ************************************************************
   always_comb
   begin
      case (cap_reg)
         SDL_CAP_IDLE:
         begin
            cap_next = load_event ? SDL_CAP_WAIT : SDL_CAP_IDLE;
         end
         SDL_CAP_WAIT:
         begin
            cap_next = (push && !load_event) ? SDL_CAP_IDLE : SDL_CAP_WAIT;
         end
         default:
         begin
            cap_next = SDL_CAP_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         cap_reg <= SDL_CAP_IDLE;
         word_reg <= `SDL_BIPOLAR_ZERO;
         overrun_reg <= 1'b0;
      end
      else
      begin
         cap_reg <= cap_next;
         word_reg <= load_event ? conv_reg : word_reg;
         overrun_reg <= overrun_reg || (load_event && (cap_reg == SDL_CAP_WAIT) && !push);
      end
   end

   // ************************************************************
   // Word buffer toward the consumer
   // ************************************************************
   sdl_fifo
   #(
      .WIDTH(`SDL_WORD_W),
      .DEPTH(FIFO_DEPTH)
   )
   u_fifo
   (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_wr_valid(cap_reg == SDL_CAP_WAIT),
      .o_wr_ready(fifo_wr_ready),
      .i_wr_data(word_reg),
      .o_rd_valid(o_code_valid),
      .i_rd_ready(i_code_ready),
      .o_rd_data(o_code_data)
   );

   // ************************************************************
   // Checks on the link clock
   // ************************************************************
   property p_shift;
      @(posedge i_sclk) disable iff (!i_latch_reset_n)
      (!i_input_latch_enable_n && i_dac_latch_enable_n)
      |=> (shift_reg == {$past(shift_reg[`SDL_MSB-1:0]), $past(i_serial_in)}) && $stable(conv_reg);
   endproperty
   a_shift: assert property (p_shift) else $error("shift pulse did not shift");

   property p_load;
      @(posedge i_sclk) disable iff (!i_latch_reset_n)
      (i_input_latch_enable_n && !i_dac_latch_enable_n)
      |=> (conv_reg == $past(shift_reg)) && $stable(shift_reg);
   endproperty
   a_load: assert property (p_load) else $error("load pulse did not copy word");

   property p_hold;
      @(posedge i_sclk) disable iff (!i_latch_reset_n)
      (i_input_latch_enable_n && i_dac_latch_enable_n)
      |=> ($stable(shift_reg) && $stable(conv_reg));
   endproperty
   a_hold: assert property (p_hold) else $error("latch changed with both enables high");

   property p_level;
      @(posedge i_sclk) disable iff (!i_latch_reset_n)
      (!i_input_latch_enable_n && i_dac_latch_enable_n) [*2]
      |=> (shift_reg[1:0] == {$past(i_serial_in, 2), $past(i_serial_in)});
   endproperty
   a_level: assert property (p_level) else $error("bit lost while enable held low");

   property p_two_wire;
      @(posedge i_sclk) disable iff (!i_latch_reset_n)
      (!i_input_latch_enable_n && !i_dac_latch_enable_n)
      |=> (conv_reg == shift_reg) && (shift_reg[0] == $past(i_serial_in));
   endproperty
   a_two_wire: assert property (p_two_wire) else $error("converter latch not transparent");

   property p_serial_out;
      @(posedge i_sclk) disable iff (!i_latch_reset_n)
      (!i_input_latch_enable_n) |=> (o_serial_out == $past(shift_reg[`SDL_MSB-1]));
   endproperty
   a_serial_out: assert property (p_serial_out) else $error("serial out not next top bit");

   property p_code;
      @(posedge i_sclk) disable iff (!i_latch_reset_n)
      (i_input_latch_enable_n && !i_dac_latch_enable_n && (shift_reg == `SDL_MINUS_FULL))
      |=> (o_minus_full && !o_plus_full && !o_bipolar_zero && (o_offset_code == `SDL_BIPOLAR_ZERO));
   endproperty
   a_code: assert property (p_code) else $error("minus full scale code misread");

   property p_flags;
      @(posedge i_sclk) disable iff (!i_latch_reset_n)
      i_latch_reset_n |-> (o_bipolar_zero == (o_dac_code == `SDL_BIPOLAR_ZERO))
         && (o_plus_full == (o_dac_code == `SDL_PLUS_FULL)) && (o_minus_full == (o_dac_code == `SDL_MINUS_FULL))
         && (o_offset_code == (o_dac_code ^ `SDL_OFFSET_FLIP));
   endproperty
   a_flags: assert property (p_flags) else $error("code flags disagree with converter latch");

   property p_clear_link;
      @(posedge i_sclk)
      (!i_latch_reset_n) |-> ((shift_reg == `SDL_BIPOLAR_ZERO) && (conv_reg == `SDL_BIPOLAR_ZERO));
   endproperty
   a_clear_link: assert property (p_clear_link) else $error("latch moved while clear held low");

   // ************************************************************
   // Checks on the system clock
   // ************************************************************
   property p_clear;
      @(posedge i_clk) disable iff (i_reset)
      (!i_latch_reset_n)
      |-> ((shift_reg == `SDL_BIPOLAR_ZERO) && (conv_reg == `SDL_BIPOLAR_ZERO) && o_bipolar_zero);
   endproperty
   a_clear: assert property (p_clear) else $error("clear did not reach bipolar zero");

   property p_capture;
      @(posedge i_clk) disable iff (i_reset)
      load_event |=> (cap_reg == SDL_CAP_WAIT) && (word_reg == $past(conv_reg));
   endproperty
   a_capture: assert property (p_capture) else $error("loaded word not captured");

   property p_word_hold;
      @(posedge i_clk) disable iff (i_reset)
      ((cap_reg == SDL_CAP_WAIT) && !fifo_wr_ready && !load_event)
      |=> ((cap_reg == SDL_CAP_WAIT) && $stable(word_reg));
   endproperty
   a_word_hold: assert property (p_word_hold) else $error("pending word lost while buffer full");

   property p_push_done;
      @(posedge i_clk) disable iff (i_reset)
      ((cap_reg == SDL_CAP_WAIT) && fifo_wr_ready && !load_event) |=> (cap_reg == SDL_CAP_IDLE);
   endproperty
   a_push_done: assert property (p_push_done) else $error("capture stuck after word was buffered");

   property p_overrun_sticky;
      @(posedge i_clk) disable iff (i_reset)
      o_overrun |=> o_overrun;
   endproperty
   a_overrun_sticky: assert property (p_overrun_sticky) else $error("overrun flag dropped without reset");

endmodule

`default_nettype wire

// file: test/sdl_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Host side of the serial link
// ************************************************************
module sdl_host_model
(
   input wire logic i_lclk,
   output logic o_sclk,
   output logic o_input_latch_enable_n,
   output logic o_dac_latch_enable_n,
   output logic o_latch_reset_n,
   output logic o_serial_in
);
   logic gate_reg;

   // Clock stands high outside frames
   assign o_sclk = gate_reg ? i_lclk : 1'b1;

   initial
   begin
      gate_reg = 1'b0;
      o_input_latch_enable_n = 1'b1;
      o_dac_latch_enable_n = 1'b1;
      o_latch_reset_n = 1'b0;
      o_serial_in = 1'b0;
   end

   // One high-low-high pulse, enables active low
   task automatic pulse(input logic ie_n, input logic de_n, input logic d);
      @(posedge i_lclk);
      gate_reg <= 1'b1;
      o_input_latch_enable_n <= ie_n;
      o_dac_latch_enable_n <= de_n;
      o_serial_in <= d;
   endtask

   // Last rise lands, then lines are released
   task automatic idle(input int n);
      @(posedge i_lclk);
      gate_reg <= 1'b0;
      o_input_latch_enable_n <= 1'b1;
      o_dac_latch_enable_n <= 1'b1;
      o_serial_in <= ~o_serial_in;
      repeat (n) @(posedge i_lclk);
   endtask

   // Word of 16 bits, top bit first
   task automatic send_word(input logic [15:0] w);
      for (int i = 15; i >= 0; i--)
         pulse(1'b0, 1'b1, w[i]);
   endtask

   task automatic set_clear(input logic v);
      @(posedge i_lclk);
      o_latch_reset_n <= v;
   endtask
endmodule

`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdl_map.svh"

module testbench;
   import sdl_pkg::*;

   logic i_clk;
   logic lclk;
   logic i_reset;
   logic code_ready;
   logic hold_ready = 1'b0;
   logic tog = 1'b0;
   wire logic sclk;
   wire logic ie_n;
   wire logic de_n;
   wire logic clr_n;
   wire logic sin;
   logic serial_out;
   logic plus_full;
   logic minus_full;
   logic bipolar_zero;
   logic code_valid;
   logic clear_active;
   logic overrun;
   sdl_word_t dac_code;
   sdl_word_t offset_code;
   sdl_word_t code_data;
   sdl_word_t last_dac = 16'h0000;
   sdl_word_t exp_q[$];
   int mismatches = 0;
   int checks = 0;
   int cycles = 0;
   int seed = 32'h0000_9256;
   logic [31:0] rnd_ready;

   always #5 i_clk = ~i_clk;
   always #7.5 lclk = ~lclk;

   sdl_host_model i_host (.i_lclk(lclk), .o_sclk(sclk), .o_input_latch_enable_n(ie_n),
      .o_dac_latch_enable_n(de_n), .o_latch_reset_n(clr_n), .o_serial_in(sin));

   sdl_serial_dac_latches #(.FIFO_DEPTH(32)) i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_sclk(sclk),
      .i_input_latch_enable_n(ie_n), .i_dac_latch_enable_n(de_n), .i_latch_reset_n(clr_n),
      .i_serial_in(sin), .o_serial_out(serial_out), .o_dac_code(dac_code), .o_offset_code(offset_code),
      .o_plus_full(plus_full), .o_minus_full(minus_full), .o_bipolar_zero(bipolar_zero),
      .o_code_data(code_data), .o_code_valid(code_valid), .i_code_ready(code_ready),
      .o_clear_active(clear_active), .o_overrun(overrun));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ************************************************************
   // Consumer stimulus, stream monitor and timeout
   // ************************************************************
   always @(posedge i_clk)
   begin
      cycles <= cycles + 1;
      rnd_ready = $random(seed);
      code_ready <= ~hold_ready & rnd_ready[0];
      if (code_valid === 1'b1 && code_ready === 1'b1)
      begin
         if (exp_q.size() > 0)
            chk(code_data, exp_q.pop_front());
         else
            chk(16'h0001, 16'h0000);
      end
      if (cycles >= 20000)
      begin
         mismatches++;
         report_and_stop();
      end
   end

   initial
   begin
      i_clk = 1'b0;
      lclk = 1'b0;
      i_reset = 1'b1;
      repeat (20) @(posedge i_clk);
      i_reset <= 1'b0;
   end

   task automatic chk_zero;
      chk(dac_code, `SDL_BIPOLAR_ZERO);
      chk(offset_code, `SDL_OFFSET_FLIP);
      chk({serial_out, bipolar_zero}, 16'h0001);
   endtask

   // Copy input latch lat into converter latch
   task automatic finish_load(input sdl_word_t lat, input logic push);
      if (push)
         exp_q.push_back(lat);
      tog = ~tog;
      i_host.pulse(1'b1, 1'b0, 1'b0);
      #1;
      chk(serial_out, lat[15]);
      chk(dac_code, last_dac);
      i_host.idle(1);
      #1;
      chk(dac_code, lat);
      chk(offset_code, lat ^ `SDL_OFFSET_FLIP);
      chk({plus_full, minus_full, bipolar_zero},
         {lat == `SDL_PLUS_FULL, lat == `SDL_MINUS_FULL, lat == `SDL_BIPOLAR_ZERO});
      last_dac = lat;
   endtask

   task automatic load_word(input sdl_word_t w, input logic push);
      i_host.send_word(w);
      finish_load(w, push);
   endtask

   initial
   begin
      logic [31:0] rnd;
      sdl_word_t w;
      sdl_word_t lat;
      sdl_word_t codes[5];
      codes = '{`SDL_PLUS_FULL, `SDL_MINUS_FULL, `SDL_BIPOLAR_ZERO, 16'hffff, 16'h4000};
      repeat (10) @(posedge lclk);
      #1;
      chk_zero();
      i_host.set_clear(1'b1);
      repeat (30) @(posedge i_clk);
      chk(clear_active, 1'b0);
      // ************************************************************
      // Code points and one random word
      // ************************************************************
      foreach (codes[k])
         load_word(codes[k], 1'b1);
      rnd = $random(seed);
      load_word(rnd[15:0], 1'b1);
      // ************************************************************
      // Hold pulses leave both latches alone
      // ************************************************************
      rnd = $random(seed);
      w = rnd[15:0];
      i_host.send_word(w);
      i_host.idle(1);
      #1;
      chk(serial_out, w[15]);
      chk(dac_code, last_dac);
      repeat (3) i_host.pulse(1'b1, 1'b1, ~w[15]);
      i_host.idle(1);
      #1;
      chk(dac_code, last_dac);
      chk(serial_out, w[15]);
      finish_load(w, 1'b1);
      // ************************************************************
      // Extra bits push older ones out
      // ************************************************************
      rnd = $random(seed);
      w = rnd[15:0];
      i_host.send_word(w);
      for (int j = 0; j < 4; j++)
         i_host.pulse(1'b0, 1'b1, j[0]);
      lat = {w[11:0], 4'b0101};
      finish_load(lat, 1'b1);
      // ************************************************************
      // Two-wire operation
      // ************************************************************
      rnd = $random(seed);
      for (int i = 0; i < 9; i++)
      begin
         lat = {lat[14:0], rnd[i]};
         exp_q.push_back(lat);
         tog = ~tog;
         i_host.pulse(1'b0, 1'b0, rnd[i]);
         i_host.idle(3);
         #1;
         chk(dac_code, lat);
         chk(serial_out, lat[15]);
      end
      // ************************************************************
      // Clear in mid-frame while the clock runs
      // ************************************************************
      if (tog)
         exp_q.push_back(`SDL_BIPOLAR_ZERO);
      tog = 1'b0;
      i_host.pulse(1'b0, 1'b1, 1'b1);
      i_host.pulse(1'b0, 1'b1, 1'b0);
      i_host.set_clear(1'b0);
      repeat (20) @(posedge lclk);
      #1;
      chk_zero();
      chk(clear_active, 1'b1);
      i_host.idle(1);
      i_host.set_clear(1'b1);
      last_dac = `SDL_BIPOLAR_ZERO;
      repeat (10) @(posedge i_clk);
      chk(clear_active, 1'b0);
      // ************************************************************
      // Buffer filled until refused, then drained
      // ************************************************************
      for (int i = 0; i < 3000 && exp_q.size() > 0; i++)
         @(posedge i_clk);
      chk(overrun, 1'b0);
      hold_ready <= 1'b1;
      repeat (3) @(posedge i_clk);
      for (int i = 0; i < 35; i++)
      begin
         rnd = $random(seed);
         load_word(rnd[15:0], i < 33 || i == 34);
      end
      repeat (10) @(posedge i_clk);
      chk(overrun, 1'b1);
      hold_ready <= 1'b0;
      for (int i = 0; i < 5000 && exp_q.size() > 0; i++)
         @(posedge i_clk);
      repeat (10) @(posedge i_clk);
      chk(exp_q.size() == 0, 1'b1);
      report_and_stop();
   end
endmodule

`default_nettype wire
